/* File: verilog/kpi_keypad_match.v */
// keypad pattern-match interrupt unit with pin routing, input filter and sticky flag
`timescale 1ns/1ps
`include "kpi_map.vh"
module kpi_keypad_match #(
  parameter WIDTH = 8
) (
  input wire clk_sys,
  input wire rstn,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire route_page_sel,
  input wire [7:0] port1_in,
  input wire [7:0] port2_in,
  input wire [7:0] port3_in,
  input wire [1:0] port4_in,
  input wire [1:0] port6_in,
  input wire keypad_irq_enable,
  input wire global_irq_enable,
  output reg [7:0] sfr_rdata,
  output reg keypad_irq,
  output reg keypad_wake
);
  reg [7:0] keypad_pattern_value;
  reg [7:0] keypad_input_mask;
  reg [4:0] route;
  reg match_polarity;
  reg [1:0] input_filter_select;
  reg keypad_match_flag;
  reg [7:0] raw_in;
  reg [7:0] filt_in;
  reg [7:0] samp1;
  reg [7:0] samp2;
  reg [2:0] div_cnt;
  reg slow_en;
  reg match;
  // datapath overview:
  //   pins -> routing mux -> optional three-sample filter -> masked compare
  //   -> sticky flag -> gated request and wake outputs.
  // the routing mux is purely combinational, so a route change is seen by
  // the filter on the very next clock; software should clear the flag after
  // moving a pair, since the old and new pins may differ for one cycle.
  // route bits map one to one onto the stored upper five bits of the
  // auxiliary register; its low three bits belong to other blocks and are
  // neither stored nor returned here.
  // the pin inputs are taken as synchronous to the system clock, so no
  // extra synchroniser stage is inserted ahead of the filter.
  wire [1:0] pair45_pin_route = route[4:3];
  wire pair67_pin_route = route[2];
  wire pair23_pin_route = route[1];
  wire pair01_pin_route = route[0];
  wire wr_patn = sfr_wr && sfr_addr == `KPI_ADDR_PATN;
  wire wr_ctrl = sfr_wr && sfr_addr == `KPI_ADDR_CTRL;
  wire wr_mask = sfr_wr && sfr_addr == `KPI_ADDR_MASK;
  wire wr_route = sfr_wr && route_page_sel && sfr_addr == `KPI_ADDR_ROUTE;

  // pin routing per input pair
  always @* begin
    raw_in[0] = pair01_pin_route ? port4_in[0] : port1_in[0];
    raw_in[1] = pair01_pin_route ? port4_in[1] : port1_in[1];
    raw_in[2] = pair23_pin_route ? port2_in[2] : port1_in[2];
    raw_in[3] = pair23_pin_route ? port2_in[4] : port1_in[3];
    raw_in[6] = pair67_pin_route ? port3_in[0] : port1_in[6];
    raw_in[7] = pair67_pin_route ? port3_in[1] : port1_in[7];
    case (pair45_pin_route)
      2'b00: raw_in[5:4] = port1_in[5:4];
      2'b01: raw_in[5:4] = port3_in[5:4];
      2'b10: raw_in[5:4] = port6_in[1:0];
      default: raw_in[5:4] = {port2_in[1], port2_in[0]};
    endcase
  end

  // clock/6 enable for the slow filter
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      div_cnt <= 3'h0;
      slow_en <= 1'b0;
    end else begin
      slow_en <= (div_cnt == `KPI_SLOW_DIV - 3'h1);
      div_cnt <= (div_cnt == `KPI_SLOW_DIV - 3'h1) ? 3'h0 : div_cnt + 3'h1;
    end
  end

  // three-sample filter per bit: output follows only when three samples agree
  // the filter costs up to three enable periods of latency, which is
  // the price of rejecting bounce; with the slow setting a key must stay
  // down for about eighteen system clocks before the flag can react.
  // filtered values reset high so released keys, which read high through
  // their pull-ups, never look like a press just after reset.
  // switching filter mode does not flush the sample registers; the first
  // filtered value after a switch may therefore lag by one extra sample.
  // the reserved setting behaves like no filter so software cannot lock
  // the unit into a state where inputs are never seen.
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_filt
      wire take = (input_filter_select == `KPI_FILT_FAST) ||
                  (input_filter_select == `KPI_FILT_SLOW && slow_en);
      always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          samp1[i] <= 1'b1;
          samp2[i] <= 1'b1;
          filt_in[i] <= 1'b1;
        end else if (input_filter_select == `KPI_FILT_NONE ||
                     input_filter_select == 2'b11) begin
          // reserved setting treated as no filter
          samp1[i] <= raw_in[i];
          samp2[i] <= raw_in[i];
          filt_in[i] <= raw_in[i];
        end else if (take) begin
          samp1[i] <= raw_in[i];
          samp2[i] <= samp1[i];
          if (raw_in[i] == samp1[i] && samp1[i] == samp2[i])
            filt_in[i] <= raw_in[i];
        end
      end
    end
  endgenerate

  // masked comparison; unfiltered mode adds one register stage of latency
  always @* begin
    if (keypad_input_mask == 8'h00)
      match = 1'b0;
    else if (match_polarity)
      match = ((filt_in ^ keypad_pattern_value) & keypad_input_mask) == 8'h00;
    else
      match = ((filt_in ^ keypad_pattern_value) & keypad_input_mask) != 8'h00;
  end

  // register writes; reserved control bits are not stored
  // the flag starts set, so software must clear it once after reset before
  // relying on the request; until then the request follows the enables.
  // the clear only takes effect when no match is present in that cycle,
  // so a condition that still holds re-arms the flag at once; this keeps
  // a press from being lost between the read and the clear.
  // the route register decodes only while the route page is selected,
  // because its address is shared with another register on the main page.
  // writes to pattern, mask and polarity act on the comparison from the
  // next cycle on; a same-cycle flag clear is judged against the old set.
  // unmapped addresses are simply ignored, with no error indication.
  // mask and pattern are fully readable, so software can save and restore
  // them around low-power entry without keeping its own copy.
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      keypad_pattern_value <= `KPI_RST_PATN;
      keypad_input_mask <= `KPI_RST_MASK;
      route <= 5'h00;
      match_polarity <= 1'b0;
      input_filter_select <= `KPI_FILT_NONE;
      keypad_match_flag <= 1'b1;
    end else begin
      if (wr_patn)
        keypad_pattern_value <= sfr_wdata;
      if (wr_mask)
        keypad_input_mask <= sfr_wdata;
      if (wr_route)
        route <= sfr_wdata[7:3];
      if (wr_ctrl) begin
        match_polarity <= sfr_wdata[`KPI_CTRL_POL];
        input_filter_select <= sfr_wdata[`KPI_CTRL_FILT_HI:`KPI_CTRL_FILT_LO];
      end
      // set wins over a same-cycle software clear; writing one has no effect
      if (match)
        keypad_match_flag <= 1'b1;
      else if (wr_ctrl && !sfr_wdata[`KPI_CTRL_FLAG])
        keypad_match_flag <= 1'b0;
    end
  end

  // read mux and interrupt outputs, all registered
  // registering the outputs adds one cycle of latency to the request, which
  // is harmless against interrupt entry time and keeps the outputs glitch free.
  // read data returns to zero whenever no read is strobed, so the bus side
  // can merge this unit's data with others by a simple or.
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sfr_rdata <= 8'h00;
      keypad_irq <= 1'b0;
      keypad_wake <= 1'b0;
    end else begin
      keypad_irq <= keypad_match_flag && keypad_irq_enable && global_irq_enable;
      // wake asserts in any low-power state; the power controller decides which apply
      keypad_wake <= keypad_match_flag && keypad_irq_enable && global_irq_enable;
      sfr_rdata <= 8'h00;
      if (sfr_rd) begin
        case (sfr_addr)
          `KPI_ADDR_PATN: sfr_rdata <= keypad_pattern_value;
          `KPI_ADDR_CTRL: sfr_rdata <= {input_filter_select, 4'h0,
                                         match_polarity, keypad_match_flag};
          `KPI_ADDR_MASK: sfr_rdata <= keypad_input_mask;
          `KPI_ADDR_ROUTE: sfr_rdata <= route_page_sel ? {route, 3'h0} : 8'h00;
          default: sfr_rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule

/* File: include/kpi_map.vh */
// register map, field positions, reset values and timing counts of the keypad match unit
`ifndef KPI_MAP_VH
`define KPI_MAP_VH
`define KPI_ADDR_ROUTE 8'hA4
`define KPI_ADDR_PATN 8'hD5
`define KPI_ADDR_CTRL 8'hD6
`define KPI_ADDR_MASK 8'hD7
`define KPI_RST_PATN 8'hFF
`define KPI_RST_MASK 8'h00
`define KPI_RST_ROUTE 8'h00
`define KPI_CTRL_FLAG 0
`define KPI_CTRL_POL 1
`define KPI_CTRL_FILT_LO 6
`define KPI_CTRL_FILT_HI 7
`define KPI_ROUTE_P01 3
`define KPI_ROUTE_P23 4
`define KPI_ROUTE_P67 5
`define KPI_ROUTE_P45_LO 6
`define KPI_ROUTE_P45_HI 7
`define KPI_FILT_NONE 2'b00
`define KPI_FILT_FAST 2'b01
`define KPI_FILT_SLOW 2'b10
`define KPI_SLOW_DIV 3'h6
`endif

/* File: sim/kpi_pins_model.sv */
// key switches to ground on port 1 and port 4, with pull-ups on every keypad-capable port pin
`timescale 1ns/1ps
module kpi_pins_model(
  input wire [7:0] key_p1,
  input wire [1:0] key_p4,
  output wire [7:0] port1_in,
  output wire [7:0] port2_in,
  output wire [7:0] port3_in,
  output wire [1:0] port4_in,
  output wire [1:0] port6_in
);
  // a pressed key pulls low; an open key rests at the pull-up, never at a stale value
  assign port1_in = ~key_p1;
  assign port2_in = 8'hff;
  assign port3_in = 8'hff;
  assign port4_in = ~key_p4;
  assign port6_in = 2'h3;
endmodule

/* File: sim/kpi_keypad_match_sva.sv */
// assertion checker for the keypad match unit ports
`timescale 1ns/1ps
module kpi_keypad_match_sva(
  input wire clk_sys,
  input wire rstn,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire keypad_irq_enable,
  input wire global_irq_enable,
  input wire [7:0] sfr_rdata,
  input wire keypad_irq,
  input wire keypad_wake
);
  reg [7:0] mask_seen;
  reg [7:0] pat_seen;
  // shadows of pattern and mask, so readback and empty-mask quiet can be judged
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mask_seen <= 8'h00;
      pat_seen <= 8'hff;
    end else if (sfr_wr && sfr_addr == 8'hd7) begin
      mask_seen <= sfr_wdata;
    end else if (sfr_wr && sfr_addr == 8'hd5) begin
      pat_seen <= sfr_wdata;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence quiet_clear;
    mask_seen == 8'h00 && sfr_wr && sfr_addr == 8'hd6 && !sfr_wdata[0];
  endsequence
  chk_local_en_gate: assert property (!keypad_irq_enable |=> !keypad_irq)
    else $error("request without local enable");
  chk_global_en_gate: assert property (!global_irq_enable |=> !keypad_irq)
    else $error("request without global enable");
  chk_wake_follows: assert property (keypad_wake == keypad_irq)
    else $error("wake differs from request");
  chk_flag_sticky: assert property (keypad_irq && keypad_irq_enable && global_irq_enable
    && !$past(sfr_wr && sfr_addr == 8'hd6) |=> keypad_irq) else $error("flag dropped");
  chk_empty_mask: assert property (quiet_clear ##1 (mask_seen == 8'h00)[*3] |-> !keypad_irq)
    else $error("match with empty mask");
  chk_ctrl_reserved: assert property ($past(sfr_rd && sfr_addr == 8'hd6) |-> sfr_rdata[5:2] == 4'h0)
    else $error("reserved control bits not zero");
  chk_rdata_quiet: assert property (!$past(sfr_rd) |-> sfr_rdata == 8'h00)
    else $error("read data without read");
  chk_pattern_back: assert property ($past(sfr_rd && sfr_addr == 8'hd5) |-> sfr_rdata == $past(pat_seen))
    else $error("pattern readback wrong");
  chk_mask_back: assert property ($past(sfr_rd && sfr_addr == 8'hd7) |-> sfr_rdata == $past(mask_seen))
    else $error("mask readback wrong");
endmodule
bind kpi_keypad_match kpi_keypad_match_sva kpi_keypad_match_sva_i(.clk_sys, .rstn, .sfr_addr,
  .sfr_wdata, .sfr_wr, .sfr_rd, .keypad_irq_enable, .global_irq_enable, .sfr_rdata, .keypad_irq,
  .keypad_wake);

/* File: sim/tb_kpi_keypad_match.sv */
// self-checking bench for the keypad match unit
`timescale 1ns/1ps
module tb_kpi_keypad_match;
  reg clk_sys = 1'b0;
  reg rstn = 1'b0;
  reg [7:0] sfr_addr = 8'h00;
  reg [7:0] sfr_wdata = 8'h00;
  reg sfr_wr = 1'b0;
  reg sfr_rd = 1'b0;
  reg route_page_sel = 1'b0;
  reg keypad_irq_enable = 1'b1;
  reg global_irq_enable = 1'b1;
  reg [7:0] key_p1 = 8'h00;
  reg [1:0] key_p4 = 2'h0;
  wire [7:0] port1_in, port2_in, port3_in, sfr_rdata;
  wire [1:0] port4_in, port6_in;
  wire keypad_irq, keypad_wake;
  integer n_errors = 0;
  integer tests_run = 0;
  kpi_pins_model kpi_pins_model_i(.key_p1, .key_p4, .port1_in, .port2_in, .port3_in, .port4_in,
    .port6_in);
  kpi_keypad_match kpi_keypad_match_i(.clk_sys, .rstn, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd,
    .route_page_sel, .port1_in, .port2_in, .port3_in, .port4_in, .port6_in, .keypad_irq_enable,
    .global_irq_enable, .sfr_rdata, .keypad_irq, .keypad_wake);
  task check(input [7:0] seen, input [7:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  // one register access; the route page is only opened for its own address
  task acc(input w, input [7:0] a, input [7:0] d);
    begin
      @(posedge clk_sys);
      sfr_addr <= a;
      sfr_wdata <= d;
      route_page_sel <= (a == 8'ha4);
      sfr_wr <= w;
      sfr_rd <= !w;
      @(posedge clk_sys);
      sfr_wr <= 1'b0;
      sfr_rd <= 1'b0;
      #1 if (!w) check(sfr_rdata, d);
    end
  endtask
  // hold keys for n cycles, release, then let the no-filter path settle
  task press(input [7:0] k1, input [1:0] k4, input integer n);
    begin
      @(posedge clk_sys);
      key_p1 <= k1;
      key_p4 <= k4;
      repeat (n) @(posedge clk_sys);
      key_p1 <= 8'h00;
      key_p4 <= 2'h0;
      repeat (8) @(posedge clk_sys);
    end
  endtask
  task give_verdict;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  initial forever #20 clk_sys = ~clk_sys;
  // hang guard, far beyond the main sequence length
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_errors = n_errors + 1;
    give_verdict;
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    acc(0, 8'hd5, 8'hff);
    acc(0, 8'hd7, 8'h00);
    acc(0, 8'hd6, 8'h01);
    check({7'h0, keypad_irq}, 8'h01);
    // enables change on a rising edge, like every other input
    @(posedge clk_sys);
    global_irq_enable <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 check({7'h0, keypad_irq}, 8'h00);
    @(posedge clk_sys);
    global_irq_enable <= 1'b1;
    acc(1, 8'hd6, 8'h00);
    acc(1, 8'hd6, 8'h01);
    acc(0, 8'hd6, 8'h00);
    acc(1, 8'hd7, 8'h01);
    press(8'h02, 2'h0, 4);
    acc(0, 8'hd6, 8'h00);
    press(8'h01, 2'h0, 4);
    acc(0, 8'hd6, 8'h01);
    check({7'h0, keypad_wake}, 8'h01);
    acc(1, 8'ha4, 8'h08);
    acc(0, 8'ha4, 8'h08);
    acc(1, 8'hd6, 8'h00);
    press(8'h01, 2'h0, 4);
    acc(0, 8'hd6, 8'h00);
    press(8'h00, 2'h1, 4);
    acc(0, 8'hd6, 8'h01);
    acc(1, 8'ha4, 8'h00);
    // pattern fe makes the idle input differ, so the clear below loses to the set
    acc(1, 8'hd5, 8'hfe);
    acc(1, 8'hd6, 8'h02);
    acc(0, 8'hd6, 8'h03);
    acc(1, 8'hd6, 8'h02);
    acc(0, 8'hd6, 8'h02);
    press(8'h01, 2'h0, 4);
    acc(0, 8'hd6, 8'h03);
    acc(1, 8'hd5, 8'hff);
    acc(1, 8'hd6, 8'h40);
    acc(0, 8'hd6, 8'h41);
    acc(1, 8'hd6, 8'h40);
    press(8'h01, 2'h0, 1);
    acc(0, 8'hd6, 8'h40);
    press(8'h01, 2'h0, 6);
    acc(0, 8'hd6, 8'h41);
    // slow filter: a short press misses, a long one spans three slow samples
    acc(1, 8'hd6, 8'h80);
    press(8'h01, 2'h0, 2);
    acc(0, 8'hd6, 8'h80);
    press(8'h01, 2'h0, 24);
    acc(0, 8'hd6, 8'h81);
    give_verdict;
  end
endmodule
